//--- shared/prox_cfg_regs.svh
// Register offsets, field positions and reset values of the configuration bank
`ifndef PROX_CFG_REGS_SVH
`define PROX_CFG_REGS_SVH

// Register offsets
`define ADDR_STATUS 8'h9B
`define ADDR_PD_SELECT 8'hAA
`define ADDR_INT_BEHAV 8'hAB
`define ADDR_PULSE_CTRL 8'hAE
`define ADDR_PROX_FILTER 8'hB3

// Reset values
`define RST_PD_SELECT 8'h02
`define RST_INT_BEHAV 8'h04
`define RST_PULSE_CTRL 8'h3F
`define RST_PROX_FILTER 8'h00
`define RST_STATUS 8'h00

// Field positions
`define PD_SELECT_MSB 1
`define PD_SELECT_LSB 0
`define BIT_READ_CLEAR 7
`define BIT_SLEEP_AFTER_INT 4
`define BIT_PULSE_DISABLE 6
`define AVG_DEPTH_MSB 1
`define AVG_DEPTH_LSB 0
`define BIT_PROX_FLAG 4

// Widths and depths
`define RESULT_WIDTH 14
`define REDUCED_WIDTH 10
`define AVG_HISTORY 8
`define AVG_SUM_WIDTH 17

`endif

//--- shared/prox_cfg_pkg.sv
// Types shared by the proximity configuration bank and its helpers
`include "prox_cfg_regs.svh"

package prox_cfg_pkg;

	typedef enum logic [1:0] {
		PD_NONE = 2'h0,
		PD_FAR = 2'h1,
		PD_NEAR = 2'h2,
		PD_BOTH = 2'h3
	} photodiode_select_t;

	typedef enum logic [1:0] {
		AVG_OFF = 2'h0,
		AVG_2 = 2'h1,
		AVG_4 = 2'h2,
		AVG_8 = 2'h3
	} moving_average_depth_t;

	typedef enum logic [2:0] {
		OSC_OFF = 3'h1,
		OSC_RUN = 3'h2,
		OSC_SLEEP = 3'h4
	} osc_state_t;

	typedef logic [`RESULT_WIDTH-1:0] result_t;

	typedef struct packed {
		logic [`AVG_HISTORY-1:0][`RESULT_WIDTH-1:0] hist;
		moving_average_depth_t depth;
		result_t out_data;
		logic out_valid;
	} avg_state_t;

	typedef struct packed {
		osc_state_t state;
	} osc_ctl_t;

	typedef struct packed {
		logic [7:0] pd_cfg;
		logic [7:0] int_cfg;
		logic [7:0] pulse_cfg;
		logic [7:0] filter_cfg;
		logic [7:0] status;
		logic [7:0] rdata;
		logic [15:0] result;
		logic result_valid;
		logic below_low;
		logic above_high;
		logic irq_oe;
	} cfg_state_t;

endpackage

//--- verilog/prox_moving_average.sv
// Running average over the last 1, 2, 4 or 8 hardware-averaged results
`timescale 1ns/10ps
`include "prox_cfg_regs.svh"

module prox_moving_average (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Depth selection
	input wire logic [1:0] depth,
	// Incoming results
	input wire logic [`RESULT_WIDTH-1:0] in_data,
	input wire logic in_valid,
	// Filtered results
	output logic [`RESULT_WIDTH-1:0] out_data,
	output logic out_valid
);

	prox_cfg_pkg::avg_state_t s;
	prox_cfg_pkg::avg_state_t next_s;
	logic [`AVG_HISTORY-1:0][`RESULT_WIDTH-1:0] shifted;
	logic [`AVG_HISTORY-1:0][`RESULT_WIDTH-1:0] term;
	logic [3:0] used;

	assign shifted = {s.hist[`AVG_HISTORY-2:0], in_data};
	assign used = 4'(1) << s.depth;

	genvar i;
	generate
		for (i = 0; i < `AVG_HISTORY; i++) begin : g_term
			assign term[i] = (4'(i) < used) ? shifted[i] : '0;
		end
	endgenerate

	always_comb begin
		logic [`AVG_SUM_WIDTH-1:0] sum;
		sum = '0;
		next_s = s;
		next_s.out_valid = 1'b0;
		for (int k = 0; k < `AVG_HISTORY; k++) begin
			sum = sum + `AVG_SUM_WIDTH'(term[k]);
		end
		// Stale history from another depth would skew the first results
		if (prox_cfg_pkg::moving_average_depth_t'(depth) != s.depth) begin
			next_s.hist = '0;
			next_s.depth = prox_cfg_pkg::moving_average_depth_t'(depth);
		end else if (in_valid) begin
			next_s.hist = shifted;
			next_s.out_data = `RESULT_WIDTH'(sum >> s.depth);
			next_s.out_valid = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s <= '{hist: '0, depth: prox_cfg_pkg::AVG_OFF, out_data: '0, out_valid: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign out_data = s.out_data;
	assign out_valid = s.out_valid;

endmodule

//--- verilog/prox_osc_control.sv
// Oscillator run, off and sleep-after-interrupt control
`timescale 1ns/10ps

module prox_osc_control (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Controls
	input wire logic power_on_bit,
	input wire logic sleep_after_interrupt,
	// Events
	input wire logic irq_asserted,
	input wire logic cycle_done,
	input wire logic flags_cleared,
	// Oscillator
	output logic osc_enable
);

	prox_cfg_pkg::osc_ctl_t s;
	prox_cfg_pkg::osc_ctl_t next_s;

	always_comb begin
		next_s = s;
		if (!power_on_bit) begin
			next_s.state = prox_cfg_pkg::OSC_OFF;
		end else begin
			unique case (s.state)
				prox_cfg_pkg::OSC_OFF: begin
					next_s.state = prox_cfg_pkg::OSC_RUN;
				end
				prox_cfg_pkg::OSC_RUN: begin
					// Decided only at the end of a proximity cycle
					if (cycle_done && irq_asserted && sleep_after_interrupt) begin
						next_s.state = prox_cfg_pkg::OSC_SLEEP;
					end
				end
				prox_cfg_pkg::OSC_SLEEP: begin
					if (flags_cleared) begin
						next_s.state = prox_cfg_pkg::OSC_RUN;
					end
				end
				default: begin
					next_s.state = prox_cfg_pkg::OSC_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s <= '{state: prox_cfg_pkg::OSC_OFF};
		end else begin
			s <= next_s;
		end
	end

	// Power-on bit itself is left untouched while asleep
	assign osc_enable = (s.state == prox_cfg_pkg::OSC_RUN);

endmodule

//--- verilog/proximity_config_regs.sv
// Proximity configuration registers with status flags, filtering and sleep control
//
// What this block does
// - With clear-on-read set, reading the status register clears its flags.
// - Sleep-after-interrupt decides the mode when a proximity cycle ends.
// - Enabled proximity flag drives the interrupt pin; with sleep set, oscillator stops.
// - Asleep, the device acts powered off yet power-on still reads 1.
// - A host clear of the proximity flag (bit 4), or power-on going to 0 and back to 1, wakes the sleeping oscillator.
// - Pulse-control disable bit 6 turns off automatic pulse control; resets to 0.
// - Averaging depth 00 none, 01/10/11 average 2, 4 or 8 values.
// - Averaged result is reported and compared with thresholds.
// - Averaging is fed by the hardware averaging stage output.
// - Writing 1 to a status bit clears that flag, unless the engine sets it in the same cycle.
// - Pulse control off: 10-bit result, upper 8 bits compared with thresholds.
`timescale 1ns/10ps
`include "prox_cfg_regs.svh"

module proximity_config_regs (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Register port from the serial host controller
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Bits held in neighbouring registers
	input wire logic power_on_bit,
	input wire logic proximity_irq_enable,
	// Status flag events from the proximity engine
	input wire logic [7:0] flag_set,
	input wire logic cycle_done,
	// Hardware-averaged proximity results
	input wire logic [`RESULT_WIDTH-1:0] hw_avg_result,
	input wire logic hw_avg_valid,
	// Thresholds
	input wire logic [`RESULT_WIDTH-1:0] low_threshold,
	input wire logic [`RESULT_WIDTH-1:0] high_threshold,
	// Reported result and threshold crossings
	output logic [15:0] proximity_result,
	output logic result_valid,
	output logic below_low,
	output logic above_high,
	// Front-end controls
	output logic far_photodiode_en,
	output logic near_photodiode_en,
	output logic automatic_pulse_regulation,
	output logic osc_enable,
	// Open-drain interrupt pin
	output logic irq_pin_out,
	output logic irq_pin_oe
);

	prox_cfg_pkg::cfg_state_t s;
	prox_cfg_pkg::cfg_state_t next_s;

	logic [7:0] clear_mask;
	logic [7:0] read_value;
	logic [7:0] next_status;
	logic status_write;
	logic status_read;
	logic read_clear;
	logic sleep_after_interrupt;
	logic pulse_control_disable;
	logic [1:0] moving_average_depth;
	logic irq_asserted;
	logic flags_cleared;
	logic [`RESULT_WIDTH-1:0] avg_data;
	logic avg_valid;
	logic [`RESULT_WIDTH-1:0] cmp_value;
	logic [`RESULT_WIDTH-1:0] cmp_low;
	logic [`RESULT_WIDTH-1:0] cmp_high;
	prox_cfg_pkg::photodiode_select_t photodiode_select;

	// Field extraction
	assign read_clear = s.int_cfg[`BIT_READ_CLEAR];
	assign sleep_after_interrupt = s.int_cfg[`BIT_SLEEP_AFTER_INT];
	assign pulse_control_disable = s.pulse_cfg[`BIT_PULSE_DISABLE];
	assign moving_average_depth = s.filter_cfg[`AVG_DEPTH_MSB:`AVG_DEPTH_LSB];
	assign photodiode_select =
		prox_cfg_pkg::photodiode_select_t'(s.pd_cfg[`PD_SELECT_MSB:`PD_SELECT_LSB]);

	// Host accesses to the status register
	assign status_write = reg_wr && (reg_addr == `ADDR_STATUS);
	assign status_read = reg_rd && (reg_addr == `ADDR_STATUS);

	always_comb begin
		clear_mask = 8'h00;
		if (status_write) begin
			clear_mask = reg_wdata;
		end
		if (status_read && read_clear) begin
			clear_mask = 8'hFF;
		end
	end

	// Wake only when the proximity flag is really gone; a fresh set keeps it asleep
	assign flags_cleared = clear_mask[`BIT_PROX_FLAG] && !flag_set[`BIT_PROX_FLAG];

	assign irq_asserted = s.status[`BIT_PROX_FLAG] && proximity_irq_enable;

	// Per flag: an engine set beats a host clear landing in the same cycle
	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_flag
			assign next_status[b] = flag_set[b] || (s.status[b] && !clear_mask[b]);
		end
	endgenerate

	// Read mux
	always_comb begin
		read_value = 8'h00;
		unique case (reg_addr)
			`ADDR_STATUS: begin
				read_value = s.status;
			end
			`ADDR_PD_SELECT: begin
				read_value = s.pd_cfg;
			end
			`ADDR_INT_BEHAV: begin
				read_value = s.int_cfg;
			end
			`ADDR_PULSE_CTRL: begin
				read_value = s.pulse_cfg;
			end
			`ADDR_PROX_FILTER: begin
				read_value = s.filter_cfg;
			end
			default: begin
				read_value = 8'h00;
			end
		endcase
	end

	// Moving average sits behind the hardware averaging stage
	prox_moving_average u_moving_average (
		.mclk(mclk),
		.nrst(nrst),
		.depth(moving_average_depth),
		.in_data(hw_avg_result),
		.in_valid(hw_avg_valid),
		.out_data(avg_data),
		.out_valid(avg_valid)
	);

	// Threshold operands depend on pulse control
	always_comb begin
		cmp_value = avg_data;
		cmp_low = low_threshold;
		cmp_high = high_threshold;
		if (pulse_control_disable) begin
			// Only the top byte of the 10-bit value is compared
			cmp_value = `RESULT_WIDTH'(avg_data[`REDUCED_WIDTH-1:2]);
			cmp_low = `RESULT_WIDTH'(low_threshold[7:0]);
			cmp_high = `RESULT_WIDTH'(high_threshold[7:0]);
		end
	end

	always_comb begin
		next_s = s;
		next_s.result_valid = 1'b0;
		next_s.below_low = 1'b0;
		next_s.above_high = 1'b0;

		// Configuration writes store every bit, reserved ones included
		if (reg_wr) begin
			unique case (reg_addr)
				`ADDR_PD_SELECT: begin
					next_s.pd_cfg = reg_wdata;
				end
				`ADDR_INT_BEHAV: begin
					next_s.int_cfg = reg_wdata;
				end
				`ADDR_PULSE_CTRL: begin
					next_s.pulse_cfg = reg_wdata;
				end
				`ADDR_PROX_FILTER: begin
					next_s.filter_cfg = reg_wdata;
				end
				default: begin
				end
			endcase
		end

		next_s.status = next_status;

		if (reg_rd) begin
			next_s.rdata = read_value;
		end

		if (avg_valid) begin
			next_s.result_valid = 1'b1;
			if (pulse_control_disable) begin
				// Upper 8 bits in the low byte, lower 2 bits in the high byte
				next_s.result = {6'h00, avg_data[1:0], avg_data[`REDUCED_WIDTH-1:2]};
			end else begin
				next_s.result = 16'(avg_data);
			end
			next_s.below_low = (cmp_value < cmp_low);
			next_s.above_high = (cmp_value > cmp_high);
		end

		next_s.irq_oe = irq_asserted;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s <= '{
				pd_cfg: `RST_PD_SELECT,
				int_cfg: `RST_INT_BEHAV,
				pulse_cfg: `RST_PULSE_CTRL,
				filter_cfg: `RST_PROX_FILTER,
				status: `RST_STATUS,
				rdata: 8'h00,
				result: 16'h0000,
				result_valid: 1'b0,
				below_low: 1'b0,
				above_high: 1'b0,
				irq_oe: 1'b0
			};
		end else begin
			s <= next_s;
		end
	end

	prox_osc_control u_osc_control (
		.mclk(mclk),
		.nrst(nrst),
		.power_on_bit(power_on_bit),
		.sleep_after_interrupt(sleep_after_interrupt),
		.irq_asserted(irq_asserted),
		.cycle_done(cycle_done),
		.flags_cleared(flags_cleared),
		.osc_enable(osc_enable)
	);

	// Photodiode routing
	always_comb begin
		far_photodiode_en = 1'b0;
		near_photodiode_en = 1'b0;
		unique case (photodiode_select)
			prox_cfg_pkg::PD_NONE: begin
			end
			prox_cfg_pkg::PD_FAR: begin
				far_photodiode_en = 1'b1;
			end
			prox_cfg_pkg::PD_NEAR: begin
				near_photodiode_en = 1'b1;
			end
			prox_cfg_pkg::PD_BOTH: begin
				far_photodiode_en = 1'b1;
				near_photodiode_en = 1'b1;
			end
		endcase
	end

	assign automatic_pulse_regulation = !pulse_control_disable;

	assign reg_rdata = s.rdata;
	assign proximity_result = s.result;
	assign result_valid = s.result_valid;
	assign below_low = s.below_low;
	assign above_high = s.above_high;

	// Open drain: only ever pulls low
	assign irq_pin_out = 1'b0;
	assign irq_pin_oe = s.irq_oe;

endmodule

//--- verif/proximity_config_regs_sva.sv
// Port-level checker for the proximity configuration bank
`timescale 1ns/10ps
`include "prox_cfg_regs.svh"

module proximity_config_regs_sva (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Controls and events
	input wire logic power_on_bit,
	input wire logic proximity_irq_enable,
	input wire logic [7:0] flag_set,
	input wire logic hw_avg_valid,
	// Outputs watched
	input wire logic result_valid,
	input wire logic below_low,
	input wire logic above_high,
	input wire logic far_photodiode_en,
	input wire logic near_photodiode_en,
	input wire logic automatic_pulse_regulation,
	input wire logic osc_enable,
	input wire logic irq_pin_out,
	input wire logic irq_pin_oe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	a_pulse_ctrl_bit: assert property (reg_wr && reg_addr == `ADDR_PULSE_CTRL |=>
		automatic_pulse_regulation == !$past(reg_wdata[6])) else $error("pulse control bit");
	a_pd_select_map: assert property (reg_wr && reg_addr == `ADDR_PD_SELECT |=>
		{near_photodiode_en, far_photodiode_en} == $past(reg_wdata[1:0]))
		else $error("photodiode decode");
	a_osc_needs_power: assert property (!power_on_bit |=> !osc_enable)
		else $error("oscillator on without power");
	a_result_latency: assert property (hw_avg_valid &&
		!$past(reg_wr && reg_addr == `ADDR_PROX_FILTER) |-> ##2 result_valid)
		else $error("result late");
	a_compare_with_result: assert property ((below_low || above_high) |-> result_valid)
		else $error("threshold pulse alone");
	a_irq_pin_asserts: assert property (flag_set[4] && proximity_irq_enable
		##1 proximity_irq_enable |=> irq_pin_oe) else $error("interrupt pin not asserted");
	a_irq_open_drain: assert property (irq_pin_out == 1'b0)
		else $error("interrupt pin driven high");
	a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {`ADDR_STATUS,
		`ADDR_PD_SELECT, `ADDR_INT_BEHAV, `ADDR_PULSE_CTRL, `ADDR_PROX_FILTER})
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed");

	c_sleep: cover property ($fell(osc_enable) && power_on_bit);
	c_above: cover property (result_valid && above_high);
	c_below: cover property (result_valid && below_low);
endmodule

//--- verif/host_bus_model.sv
// Host side of the register port: single-byte writes and reads
`timescale 1ns/10ps

module host_bus_model (
	// Clock
	input wire logic mclk,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Callers keep reserved bits at their reset values
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
endmodule

//--- verif/tb.sv
// Self-checking bench for the proximity configuration bank
`timescale 1ns/10ps
`include "prox_cfg_regs.svh"

module tb;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, flag_set = 8'h00;
	logic reg_wr, reg_rd, power_on_bit = 1'b1, proximity_irq_enable = 1'b0;
	logic cycle_done = 1'b0, hw_avg_valid = 1'b0;
	logic [13:0] hw_avg_result = 14'h0000, low_threshold = 14'h0014, high_threshold = 14'h0028;
	logic [15:0] proximity_result;
	logic result_valid, below_low, above_high, far_en, near_en, apr, osc_enable, irq_out, irq_oe;
	logic [13:0] hist [8];
	logic apc_off = 1'b0;
	int num_errors = 0;
	int check_count = 0;

	always #20 mclk = ~mclk;

	host_bus_model host_bus_model_inst (.mclk(mclk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	proximity_config_regs proximity_config_regs_inst (.mclk(mclk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .power_on_bit(power_on_bit),
		.proximity_irq_enable(proximity_irq_enable), .flag_set(flag_set),
		.cycle_done(cycle_done), .hw_avg_result(hw_avg_result), .hw_avg_valid(hw_avg_valid),
		.low_threshold(low_threshold), .high_threshold(high_threshold),
		.proximity_result(proximity_result), .result_valid(result_valid),
		.below_low(below_low), .above_high(above_high), .far_photodiode_en(far_en),
		.near_photodiode_en(near_en), .automatic_pulse_regulation(apr),
		.osc_enable(osc_enable), .irq_pin_out(irq_out), .irq_pin_oe(irq_oe));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host_bus_model_inst.rd(a, d);
		chk(16'(d), 16'(exp));
	endtask

	task automatic flag(input logic [7:0] f);
		@(posedge mclk);
		flag_set <= f;
		@(posedge mclk);
		flag_set <= 8'h00;
	endtask

	task automatic end_cycle();
		@(posedge mclk);
		cycle_done <= 1'b1;
		@(posedge mclk);
		cycle_done <= 1'b0;
		#1;
	endtask

	// History mirrors the averager and is emptied with it on every depth change
	task automatic sample(input logic [13:0] v, input logic [1:0] dp);
		logic [16:0] s;
		logic [13:0] a;
		s = 17'h00000;
		for (int i = 7; i > 0; i--) hist[i] = hist[i-1];
		hist[0] = v;
		for (int i = 0; i < (1 << dp); i++) s += 17'(hist[i]);
		a = 14'(s >> dp);
		@(posedge mclk);
		hw_avg_result <= v;
		hw_avg_valid <= 1'b1;
		@(posedge mclk);
		hw_avg_valid <= 1'b0;
		@(posedge mclk);
		#1;
		chk(16'(result_valid), 16'h0001);
		if (apc_off) begin
			chk(proximity_result, {6'h00, a[1:0], a[9:2]});
			chk(16'({below_low, above_high}),
				16'({a[9:2] < low_threshold[7:0], a[9:2] > high_threshold[7:0]}));
		end else begin
			chk(proximity_result, {2'h0, a});
			chk(16'({below_low, above_high}), 16'({a < low_threshold, a > high_threshold}));
		end
	endtask

	initial begin
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		rdchk(`ADDR_PD_SELECT, `RST_PD_SELECT);
		rdchk(`ADDR_INT_BEHAV, `RST_INT_BEHAV);
		rdchk(`ADDR_PULSE_CTRL, `RST_PULSE_CTRL);
		rdchk(`ADDR_PROX_FILTER, `RST_PROX_FILTER);
		rdchk(`ADDR_STATUS, `RST_STATUS);
		chk(16'({near_en, far_en, apr}), 16'h0005);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			host_bus_model_inst.wr(`ADDR_PD_SELECT, 8'(i));
			#1 chk(16'({near_en, far_en}), 16'(i));
		end
		host_bus_model_inst.wr(8'hA0, 8'hFF);
		rdchk(8'hA0, 8'h00);
		host_bus_model_inst.wr(`ADDR_PULSE_CTRL, 8'h7F);
		#1 chk(16'(apr), 16'h0000);
		host_bus_model_inst.wr(`ADDR_PULSE_CTRL, 8'h3F);
		#1 chk(16'(apr), 16'h0001);
		$display("test select and pulse control done");
		for (int dp = 0; dp < 4; dp++) begin
			host_bus_model_inst.wr(`ADDR_PROX_FILTER, 8'(dp));
			hist = '{default: 14'h0000};
			repeat (8) sample(14'h0000, 2'(dp));
			for (int k = 1; k < 5; k++) sample(14'(k * 12), 2'(dp));
		end
		host_bus_model_inst.wr(`ADDR_PROX_FILTER, 8'h00);
		hist = '{default: 14'h0000};
		host_bus_model_inst.wr(`ADDR_PULSE_CTRL, 8'h7F);
		apc_off = 1'b1;
		sample(14'h02A5, 2'h0);
		sample(14'h0040, 2'h0);
		apc_off = 1'b0;
		host_bus_model_inst.wr(`ADDR_PULSE_CTRL, 8'h3F);
		$display("test averaging done");
		flag(8'h01);
		rdchk(`ADDR_STATUS, 8'h01);
		rdchk(`ADDR_STATUS, 8'h01);
		host_bus_model_inst.wr(`ADDR_STATUS, 8'h01);
		rdchk(`ADDR_STATUS, 8'h00);
		host_bus_model_inst.wr(`ADDR_INT_BEHAV, 8'h84);
		flag(8'h03);
		rdchk(`ADDR_STATUS, 8'h03);
		rdchk(`ADDR_STATUS, 8'h00);
		$display("test status clearing done");
		proximity_irq_enable <= 1'b1;
		host_bus_model_inst.wr(`ADDR_INT_BEHAV, 8'h14);
		flag(8'h10);
		@(posedge mclk);
		#1 chk(16'({irq_oe, osc_enable}), 16'h0003);
		end_cycle();
		chk(16'(osc_enable), 16'h0000);
		host_bus_model_inst.wr(`ADDR_STATUS, 8'h01);
		sample(14'h0005, 2'h0);
		chk(16'(osc_enable), 16'h0000);
		host_bus_model_inst.wr(`ADDR_STATUS, 8'h10);
		#1 chk(16'(osc_enable), 16'h0001);
		@(posedge mclk);
		#1 chk(16'(irq_oe), 16'h0000);
		host_bus_model_inst.wr(`ADDR_INT_BEHAV, 8'h04);
		flag(8'h10);
		end_cycle();
		chk(16'(osc_enable), 16'h0001);
		@(posedge mclk);
		power_on_bit <= 1'b0;
		@(posedge mclk);
		#1 chk(16'(osc_enable), 16'h0000);
		@(posedge mclk);
		#1 chk(16'(osc_enable), 16'h0000);
		$display("test sleep control done");
		report_and_stop();
	end

	initial begin
		#100000;
		num_errors++;
		report_and_stop();
	end
endmodule

bind proximity_config_regs proximity_config_regs_sva proximity_config_regs_sva_inst (
	.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .power_on_bit,
	.proximity_irq_enable, .flag_set, .hw_avg_valid, .result_valid, .below_low, .above_high,
	.far_photodiode_en, .near_photodiode_en, .automatic_pulse_regulation, .osc_enable,
	.irq_pin_out, .irq_pin_oe);
